/* pkg/ssd_pkg.sv */
`default_nettype none
package ssd_pkg;
    // Fixed I/O ports seen by the device
    localparam logic [15:0] RTC_INDEX_PORT = 16'h0070;
    localparam logic [15:0] SYS_CTRL_PORT = 16'h0061;
    localparam logic [15:0] INDEX_LOW_PORT = 16'h0074;
    localparam logic [15:0] INDEX_HIGH_PORT = 16'h0075;
    localparam logic [7:0] INDEX_GATE_VALUE = 8'h8d;
    localparam int NMI_MASK_BIT = 7;

    // Window pointer
    localparam logic [7:0] PTR_RESET = 8'h07;
    localparam logic [7:0] WINDOW_LOW_BYTE = 8'h00;
    localparam logic [23:0] PTR_MEM_ADDR_NARROW = 24'h0ffffd;
    localparam logic [23:0] PTR_MEM_ADDR_WIDE = 24'hfffffd;
    localparam logic [19:0] NARROW_ADDR_MASK = 20'hfffff;

    // Configuration space indexes
    localparam int CFG_EXPAND_BIT = 7;
    localparam logic [6:0] CFG_PERIPHERAL_SETUP = 7'h20;
    localparam logic [6:0] CFG_PORT_A_CONTROL = 7'h21;
    localparam logic [6:0] CFG_PORT_A_START_LOW = 7'h22;
    localparam logic [6:0] CFG_PORT_A_START_HIGH = 7'h23;
    localparam logic [6:0] CFG_PORT_B_CONTROL = 7'h24;
    localparam logic [6:0] CFG_PORT_B_START_LOW = 7'h25;
    localparam logic [6:0] CFG_PORT_B_START_HIGH = 7'h26;
    localparam logic [2:0] SLOT_NONE = 3'h7;

    // Peripheral setup fields
    localparam int PS_MODE_BIT = 0;
    localparam int PS_SER2_EN_BIT = 1;
    localparam int PS_SER1_EN_BIT = 2;
    localparam int PS_SER2_PRI_BIT = 3;
    localparam int PS_TIMER_TEST_BIT = 7;
    localparam logic [7:0] PS_WRITABLE_MASK = 8'h8f;
    localparam logic [7:0] PS_RESET = 8'h00;

    // Port control fields
    localparam int PC_DEPTH_LSB = 0;
    localparam int PC_WIDTH_LSB = 4;
    localparam int PC_ENABLE_BIT = 7;
    localparam logic [2:0] DEPTH_RESERVED = 3'h7;
    localparam logic [7:0] PC_WRITABLE_MASK = 8'hf7;
    localparam logic [7:0] PC_RESET = 8'h00;

    // System control port fields
    localparam int SC_PARITY_DIS_BIT = 2;
    localparam int SC_CHAN_DIS_BIT = 3;
    localparam int SC_REFRESH_BIT = 4;
    localparam int SC_CHAN_ERR_BIT = 6;
    localparam int SC_PARITY_ERR_BIT = 7;
    localparam logic [1:0] SC_DIS_RESET = 2'h3;

    // Timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int CMD_BASE_NS = 70;
    localparam int CMD_STEP_NS = 140;
    localparam int REFRESH_PERIOD_NS = 15600;
    localparam logic [10:0] REFRESH_CYCLES = 11'(REFRESH_PERIOD_NS / CLK_PERIOD_NS);

    // Host command registers (word offsets)
    localparam logic [7:0] HR_ADDR = 8'h00;
    localparam logic [7:0] HR_DATA = 8'h04;
    localparam logic [7:0] HR_GO = 8'h08;
    localparam logic [7:0] HR_STATUS = 8'h0c;
    localparam logic [7:0] HR_CONFIG = 8'h10;

    typedef enum logic [1:0] {
        OP_IO_READ = 2'b00,
        OP_IO_WRITE = 2'b01,
        OP_MEM_WRITE = 2'b10,
        OP_NONE = 2'b11
    } ssd_op_t;

    // Least time, rounded up to whole cycles
    function automatic logic [7:0] cmdCycles(input logic [2:0] code);
        int ns;
        ns = (code == 3'h0) ? CMD_BASE_NS : CMD_STEP_NS * int'(code);
        return 8'((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    endfunction : cmdCycles

    function automatic logic [15:0] depthMask(input logic [2:0] code);
        return 16'((32'd2 << code) - 32'd1);
    endfunction : depthMask

    function automatic logic isPtrAddr(input logic [23:0] addr, input logic wide);
        return wide ? (addr == PTR_MEM_ADDR_WIDE)
                    : (addr[19:0] == (PTR_MEM_ADDR_NARROW[19:0] & NARROW_ADDR_MASK));
    endfunction : isPtrAddr

    function automatic logic [2:0] cfgSlot(input logic [14:0] addr, input logic expanded);
        if (expanded || addr[14:7] != 8'h00) begin
            return SLOT_NONE;
        end
        case (addr[6:0])
            CFG_PERIPHERAL_SETUP: return 3'h0;
            CFG_PORT_A_CONTROL: return 3'h1;
            CFG_PORT_A_START_LOW: return 3'h2;
            CFG_PORT_A_START_HIGH: return 3'h3;
            CFG_PORT_B_CONTROL: return 3'h4;
            CFG_PORT_B_START_LOW: return 3'h5;
            CFG_PORT_B_START_HIGH: return 3'h6;
            default: return SLOT_NONE;
        endcase
    endfunction : cfgSlot
endpackage : ssd_pkg
`default_nettype wire

/* pkg/ssd_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface ssd_if;
    logic [15:0] ioAddr;
    logic [7:0] ioData;
    logic ioRd;
    logic ioWr;
    logic [23:0] memAddr;
    logic memWr;
    logic refresh;
    logic windowStrobe;
    logic [7:0] rdData;
    logic ptrUnlocked;

    modport host_end (
        output ioAddr, ioData, ioRd, ioWr, memAddr, memWr, refresh, windowStrobe,
        input rdData, ptrUnlocked
    );
    modport device_end (
        input ioAddr, ioData, ioRd, ioWr, memAddr, memWr, refresh, windowStrobe,
        output rdData, ptrUnlocked
    );
endinterface : ssd_if
`default_nettype wire

/* rtl/ssd_port_decoder.sv */
`timescale 1ns/1ns
`default_nettype none
module ssd_port_decoder (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [7:0] control,
    input wire logic [15:0] start,
    input wire logic [15:0] ioAddr,
    input wire logic ioRd,
    input wire logic ioWr,
    output logic select
);
    import ssd_pkg::*;

    typedef struct packed {
        logic [7:0] cnt_r;
        logic sel_r;
    } ssd_dec_state_t;

    ssd_dec_state_t q;
    ssd_dec_state_t d;
    logic [2:0] depthCode;
    logic [15:0] mask;
    logic hit;

    always_comb begin
        d = q;
        depthCode = control[PC_DEPTH_LSB +: 3];
        mask = depthMask(depthCode);
        // Low start bits below the depth are ignored, so a misaligned start aliases down
        hit = control[PC_ENABLE_BIT] && (depthCode != DEPTH_RESERVED) && (ioRd || ioWr)
              && ((ioAddr & ~mask) == (start & ~mask));
        if (hit) begin
            d.cnt_r = cmdCycles(control[PC_WIDTH_LSB +: 3]);
        end else if (q.cnt_r != 8'h00) begin
            d.cnt_r = q.cnt_r - 8'h01;
        end
        d.sel_r = (d.cnt_r != 8'h00);
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign select = q.sel_r;
endmodule : ssd_port_decoder
`default_nettype wire

/* rtl/ssd_device.sv */
// The plain strobed port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
// Contract
// - 128 locations, expandable 32K, one window
// - Pointer write-only, loaded at FFFFDH/FFFFFDH
// - Window sits at 0700H after power-on
// - Reading index low 0074H unlocks pointer
// - Relock on pointer write or refresh
// - Pointer is window address upper byte
// - Software disables NMI, syncs to refresh
// - Index then window access selects location
// - Index bit 7 selects expanded space
// - 00H-3FH vendor, 40H-7FH customer
// - Registers at 20H through 26H
// - Extended mode overrides board setup bits
// - Peripheral setup holds timer, serial, mode
// - Two ports: start, depth, width, enable
// - Start aligned to port depth
// - Depth code 2 to 128 bytes
// - Width 70 to 980 ns, enable bit
// - NMI on enabled channel check, parity
// - NMI on enabled watchdog time-out
// - Companion holds pointer, drives window strobe
// - Index ports only while RTC index 8DH
// - Each port drives its own select
module ssd_device (
    ssd_if.device_end link,
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic channelCheck,
    input wire logic parityError,
    input wire logic watchdogEnable,
    input wire logic watchdogTimeout,
    input wire logic [1:0] boardSerialEn,
    output logic nmiReq,
    output logic [1:0] serialEnable,
    output logic secondSerialPrimary,
    output logic timerTest,
    output logic portASelect,
    output logic portBSelect
);
    import ssd_pkg::*;

    typedef struct packed {
        logic [7:0] rtcIndex_r;
        logic [7:0] indexLow_r;
        logic [7:0] indexHigh_r;
        logic [7:0] periph_r;
        logic [1:0][7:0] ctrl_r;
        logic [1:0][15:0] start_r;
        logic [1:0] sysDis_r;
        logic refreshToggle_r;
        logic chanFlag_r;
        logic parityFlag_r;
        logic wdogFlag_r;
        logic unlocked_r;
        logic [7:0] rdData_r;
        logic nmi_r;
        logic [1:0] serialEn_r;
    } ssd_dev_state_t;

    ssd_dev_state_t q;
    ssd_dev_state_t d;
    logic indexGate;
    logic windowHit;
    logic expanded;
    logic [14:0] cfgAddr;
    logic [2:0] slot;
    logic [1:0] portSelect;

    always_comb begin
        d = q;
        d.rdData_r = 8'h00;
        indexGate = (q.rtcIndex_r == INDEX_GATE_VALUE);
        // Only the companion knows where the window is; its strobe qualifies the access
        windowHit = link.windowStrobe && (link.ioAddr[7:0] == WINDOW_LOW_BYTE);
        expanded = q.indexLow_r[CFG_EXPAND_BIT];
        cfgAddr = expanded ? {q.indexHigh_r, q.indexLow_r[6:0]} : {8'h00, q.indexLow_r[6:0]};
        // Vendor block holds only 20H-26H here; customer block decodes to nothing
        slot = cfgSlot(cfgAddr, expanded);

        // Refresh and pointer writes relock before a same-cycle unlock is applied
        if (link.refresh) begin
            d.refreshToggle_r = ~q.refreshToggle_r;
            d.unlocked_r = 1'b0;
        end
        if (link.memWr && isPtrAddr(link.memAddr, 1'b0)) begin
            d.unlocked_r = 1'b0;
        end
        if (link.memWr && isPtrAddr(link.memAddr, 1'b1)) begin
            d.unlocked_r = 1'b0;
        end

        if (link.ioWr) begin
            if (link.ioAddr == RTC_INDEX_PORT) begin
                d.rtcIndex_r = link.ioData;
            end else if (link.ioAddr == SYS_CTRL_PORT) begin
                d.sysDis_r = {link.ioData[SC_CHAN_DIS_BIT], link.ioData[SC_PARITY_DIS_BIT]};
            end else if (link.ioAddr == INDEX_LOW_PORT && indexGate) begin
                d.indexLow_r = link.ioData;
            end else if (link.ioAddr == INDEX_HIGH_PORT && indexGate) begin
                d.indexHigh_r = link.ioData;
            end else if (windowHit) begin
                case (slot)
                    3'h0: d.periph_r = link.ioData & PS_WRITABLE_MASK;
                    3'h1: d.ctrl_r[0] = link.ioData & PC_WRITABLE_MASK;
                    3'h2: d.start_r[0][7:0] = link.ioData;
                    3'h3: d.start_r[0][15:8] = link.ioData;
                    3'h4: d.ctrl_r[1] = link.ioData & PC_WRITABLE_MASK;
                    3'h5: d.start_r[1][7:0] = link.ioData;
                    3'h6: d.start_r[1][15:8] = link.ioData;
                    default: d.periph_r = q.periph_r;
                endcase
            end
        end

        if (link.ioRd) begin
            if (link.ioAddr == SYS_CTRL_PORT) begin
                d.rdData_r[SC_PARITY_ERR_BIT] = q.parityFlag_r;
                d.rdData_r[SC_CHAN_ERR_BIT] = q.chanFlag_r;
                d.rdData_r[SC_REFRESH_BIT] = q.refreshToggle_r;
                d.rdData_r[SC_CHAN_DIS_BIT] = q.sysDis_r[1];
                d.rdData_r[SC_PARITY_DIS_BIT] = q.sysDis_r[0];
            end else if (link.ioAddr == INDEX_LOW_PORT && indexGate) begin
                // The index itself is write-only; the read only serves as the unlock key
                d.unlocked_r = 1'b1;
            end else if (windowHit) begin
                case (slot)
                    3'h0: d.rdData_r = q.periph_r;
                    3'h1: d.rdData_r = q.ctrl_r[0];
                    3'h2: d.rdData_r = q.start_r[0][7:0];
                    3'h3: d.rdData_r = q.start_r[0][15:8];
                    3'h4: d.rdData_r = q.ctrl_r[1];
                    3'h5: d.rdData_r = q.start_r[1][7:0];
                    3'h6: d.rdData_r = q.start_r[1][15:8];
                    default: d.rdData_r = 8'h00;
                endcase
            end
        end

        // Disable bits clear the sticky flags; a coincident event is ignored while disabled
        if (q.sysDis_r[1]) begin
            d.chanFlag_r = 1'b0;
        end
        if (q.sysDis_r[0]) begin
            d.parityFlag_r = 1'b0;
        end
        if (!watchdogEnable) begin
            d.wdogFlag_r = 1'b0;
        end
        if (channelCheck && !q.sysDis_r[1]) begin
            d.chanFlag_r = 1'b1;
        end
        if (parityError && !q.sysDis_r[0]) begin
            d.parityFlag_r = 1'b1;
        end
        if (watchdogTimeout && watchdogEnable) begin
            d.wdogFlag_r = 1'b1;
        end
        // Software masks NMI through the RTC index port while it moves the pointer
        d.nmi_r = (d.chanFlag_r || d.parityFlag_r || d.wdogFlag_r)
                  && !d.rtcIndex_r[NMI_MASK_BIT];

        if (d.periph_r[PS_MODE_BIT]) begin
            d.serialEn_r = {d.periph_r[PS_SER2_EN_BIT], d.periph_r[PS_SER1_EN_BIT]};
        end else begin
            d.serialEn_r = boardSerialEn;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
            q.periph_r <= PS_RESET;
            q.ctrl_r <= {PC_RESET, PC_RESET};
            q.sysDis_r <= SC_DIS_RESET;
        end else begin
            q <= d;
        end
    end

    for (genvar i = 0; i < 2; i++) begin : g_port
        ssd_port_decoder u_dec (
            .sys_clk(sys_clk),
            .resetn(resetn),
            .control(q.ctrl_r[i]),
            .start(q.start_r[i]),
            .ioAddr(link.ioAddr),
            .ioRd(link.ioRd),
            .ioWr(link.ioWr),
            .select(portSelect[i])
        );
    end

    assign portASelect = portSelect[0];
    assign portBSelect = portSelect[1];
    assign link.rdData = q.rdData_r;
    assign link.ptrUnlocked = q.unlocked_r;
    assign nmiReq = q.nmi_r;
    assign serialEnable = q.serialEn_r;
    assign secondSerialPrimary = q.periph_r[PS_SER2_PRI_BIT];
    assign timerTest = q.periph_r[PS_TIMER_TEST_BIT];
endmodule : ssd_device
`default_nettype wire

/* rtl/ssd_host.sv */
`timescale 1ns/1ns
`default_nettype none
module ssd_host (
    ssd_if.host_end link,
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [7:0] swAddr,
    input wire logic [31:0] swWrData,
    input wire logic swWr,
    input wire logic swRd,
    output logic [31:0] swRdData
);
    import ssd_pkg::*;

    typedef struct packed {
        logic [23:0] addr_r;
        logic [7:0] data_r;
        logic wide_r;
        logic [7:0] ptr_r;
        logic [15:0] ioAddr_r;
        logic [7:0] ioData_r;
        logic ioRd_r;
        logic ioWr_r;
        logic [23:0] memAddr_r;
        logic memWr_r;
        logic refresh_r;
        logic [10:0] refCnt_r;
        logic rdPend_r;
        logic [7:0] rdData_r;
        logic [31:0] swRd_r;
    } ssd_host_state_t;

    ssd_host_state_t q;
    ssd_host_state_t d;
    ssd_op_t op;

    always_comb begin
        d = q;
        d.ioRd_r = 1'b0;
        d.ioWr_r = 1'b0;
        d.memWr_r = 1'b0;
        d.refresh_r = 1'b0;
        d.swRd_r = 32'h0;
        op = OP_NONE;
        if (swWr && swAddr == HR_GO) begin
            op = ssd_op_t'(swWrData[1:0]);
        end

        if (q.refCnt_r == REFRESH_CYCLES - 11'h001) begin
            d.refCnt_r = 11'h000;
            d.refresh_r = 1'b1;
        end else begin
            d.refCnt_r = q.refCnt_r + 11'h001;
        end

        if (swWr) begin
            case (swAddr)
                HR_ADDR: d.addr_r = swWrData[23:0];
                HR_DATA: d.data_r = swWrData[7:0];
                HR_CONFIG: d.wide_r = swWrData[0];
                default: d.wide_r = q.wide_r;
            endcase
        end
        case (op)
            OP_IO_READ: d.ioRd_r = 1'b1;
            OP_IO_WRITE: d.ioWr_r = 1'b1;
            OP_MEM_WRITE: d.memWr_r = 1'b1;
            default: d.ioRd_r = 1'b0;
        endcase
        if (op != OP_NONE) begin
            d.ioAddr_r = q.addr_r[15:0];
            d.memAddr_r = q.addr_r;
            d.ioData_r = q.data_r;
        end

        // Pointer is write-only and only loads while the device reports it unlocked
        if (q.memWr_r && isPtrAddr(q.memAddr_r, q.wide_r) && link.ptrUnlocked) begin
            d.ptr_r = q.ioData_r;
        end

        d.rdPend_r = q.ioRd_r;
        if (q.rdPend_r) begin
            d.rdData_r = link.rdData;
        end

        if (swRd) begin
            case (swAddr)
                HR_ADDR: d.swRd_r = {8'h00, q.addr_r};
                HR_DATA: d.swRd_r = {24'h0, q.data_r};
                HR_STATUS: d.swRd_r = {23'h0, q.rdPend_r || q.ioRd_r, q.rdData_r};
                HR_CONFIG: d.swRd_r = {31'h0, q.wide_r};
                default: d.swRd_r = 32'h0;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
            q.ptr_r <= PTR_RESET;
        end else begin
            q <= d;
        end
    end

    assign link.ioAddr = q.ioAddr_r;
    assign link.ioData = q.ioData_r;
    assign link.ioRd = q.ioRd_r;
    assign link.ioWr = q.ioWr_r;
    assign link.memAddr = q.memAddr_r;
    assign link.memWr = q.memWr_r;
    assign link.refresh = q.refresh_r;
    // Window sits at the pointer byte times 256
    assign link.windowStrobe = (q.ioRd_r || q.ioWr_r) && (q.ioAddr_r == {q.ptr_r, WINDOW_LOW_BYTE});
    assign swRdData = q.swRd_r;
endmodule : ssd_host
`default_nettype wire

/* dv/ssd_checker_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module ssd_checker_sva (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [15:0] ioAddr,
    input wire logic [7:0] ioData,
    input wire logic ioRd,
    input wire logic ioWr,
    input wire logic [23:0] memAddr,
    input wire logic memWr,
    input wire logic refresh,
    input wire logic windowStrobe,
    input wire logic [7:0] rdData,
    input wire logic ptrUnlocked
);
    import ssd_pkg::*;
    typedef struct packed {
        logic [7:0] rtc;
        logic [7:0] ptr;
        logic [10:0] gap;
        logic seen;
    } ssd_chk_t;
    ssd_chk_t st_r;
    ssd_chk_t st_nxt;
    logic unlockRd;
    logic ptrWr;
    assign unlockRd = ioRd && ioAddr == INDEX_LOW_PORT && st_r.rtc == INDEX_GATE_VALUE;
    // Low 20 bits only: the bench loads the wide address just under the wide setting
    assign ptrWr = memWr && memAddr[19:0] == 20'hffffd;
    always_comb begin
        st_nxt = st_r;
        if (ioWr && ioAddr == RTC_INDEX_PORT) st_nxt.rtc = ioData;
        if (ptrWr && ptrUnlocked) st_nxt.ptr = ioData;
        st_nxt.gap = refresh ? 11'h1 : st_r.gap + 11'h1;
        if (refresh) st_nxt.seen = 1'b1;
    end
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) st_r <= '{rtc: 8'h00, ptr: PTR_RESET, gap: 11'h0, seen: 1'b0};
        else st_r <= st_nxt;
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);
    a_read_slot: assert property (rdData != 8'h00 |-> $past(ioRd))
        else $error("read data outside read slot");
    a_unlock_cause: assert property ($rose(ptrUnlocked) |-> $past(unlockRd))
        else $error("pointer unlocked without gated index read");
    a_unlock_open: assert property (unlockRd |=> ptrUnlocked)
        else $error("index read did not unlock pointer");
    a_gate_closed: assert property (ioRd && ioAddr == INDEX_LOW_PORT && !unlockRd && !ptrUnlocked |=> !ptrUnlocked)
        else $error("ungated index read unlocked pointer");
    a_lock_write: assert property (ptrUnlocked && ptrWr |=> !ptrUnlocked)
        else $error("pointer write did not relock");
    a_lock_refresh: assert property (ptrUnlocked && refresh && !unlockRd |=> !ptrUnlocked)
        else $error("refresh did not relock");
    a_unlock_hold: assert property (ptrUnlocked && !refresh && !memWr |=> ptrUnlocked)
        else $error("pointer relocked without cause");
    a_window_decode: assert property ((ioRd || ioWr) |-> windowStrobe == (ioAddr == {st_r.ptr, WINDOW_LOW_BYTE}))
        else $error("window strobe does not follow pointer");
    a_strobe_cycle: assert property (windowStrobe |-> ioRd || ioWr)
        else $error("window strobe outside io cycle");
    a_refresh_period: assert property (st_r.seen |-> refresh == (st_r.gap == REFRESH_CYCLES))
        else $error("refresh spacing wrong");
    c_unlock: cover property (unlockRd ##1 ptrUnlocked);
    c_relock_refresh: cover property (ptrUnlocked && refresh);
    c_ptr_load: cover property (ptrUnlocked && ptrWr);
    c_window_read: cover property (windowStrobe && ioRd);
endmodule : ssd_checker_sva
`default_nettype wire

/* dv/test_setup_space_port_decode.sv */
`timescale 1ns/1ns
`default_nettype none
module test_setup_space_port_decode;
    import ssd_pkg::*;
    logic sys_clk, resetn, channelCheck, parityError, watchdogEnable, watchdogTimeout;
    logic nmiReq, secondSerialPrimary, timerTest, portASelect, portBSelect, swWr, swRd;
    logic [1:0] boardSerialEn, serialEnable;
    logic [7:0] swAddr, ptr;
    logic [31:0] swWrData, swRdData, rd;
    int errorCnt = 0;
    int checks = 0;
    int na, nb, n;
    ssd_if link();
    ssd_device u_ssd_device (.link(link), .sys_clk(sys_clk), .resetn(resetn), .channelCheck(channelCheck),
        .parityError(parityError), .watchdogEnable(watchdogEnable), .watchdogTimeout(watchdogTimeout),
        .boardSerialEn(boardSerialEn), .nmiReq(nmiReq), .serialEnable(serialEnable),
        .secondSerialPrimary(secondSerialPrimary), .timerTest(timerTest), .portASelect(portASelect),
        .portBSelect(portBSelect));
    ssd_host u_ssd_host (.link(link), .sys_clk(sys_clk), .resetn(resetn), .swAddr(swAddr), .swWrData(swWrData),
        .swWr(swWr), .swRd(swRd), .swRdData(swRdData));
    ssd_checker_sva u_ssd_checker_sva (.sys_clk(sys_clk), .resetn(resetn), .ioAddr(link.ioAddr),
        .ioData(link.ioData), .ioRd(link.ioRd), .ioWr(link.ioWr), .memAddr(link.memAddr), .memWr(link.memWr),
        .refresh(link.refresh), .windowStrobe(link.windowStrobe), .rdData(link.rdData),
        .ptrUnlocked(link.ptrUnlocked));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errorCnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic results();
        $display("checks=%0d errors=%0d", checks, errorCnt);
        if (errorCnt == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : results
    task automatic swWrite(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        swAddr <= a;
        swWrData <= d;
        swWr <= 1'b1;
        @(posedge sys_clk);
        swWr <= 1'b0;
    endtask : swWrite
    task automatic io(input ssd_op_t op, input logic [23:0] a, input logic [7:0] d);
        swWrite(HR_ADDR, 32'(a));
        swWrite(HR_DATA, 32'(d));
        swWrite(HR_GO, 32'(op));
    endtask : io
    task automatic ioRead(input logic [15:0] a, output logic [31:0] d);
        io(OP_IO_READ, 24'(a), 8'h00);
        repeat (3) @(posedge sys_clk);
        @(posedge sys_clk);
        swAddr <= HR_STATUS;
        swRd <= 1'b1;
        @(posedge sys_clk);
        swRd <= 1'b0;
        #1 d = {23'h0, swRdData[8:0]};
    endtask : ioRead
    task automatic cfgWr(input logic [7:0] i, input logic [7:0] d);
        io(OP_IO_WRITE, 24'h74, i);
        io(OP_IO_WRITE, {8'h00, ptr, 8'h00}, d);
    endtask : cfgWr
    task automatic cfgChk(input logic [7:0] i, input logic [7:0] e);
        io(OP_IO_WRITE, 24'h74, i);
        ioRead({ptr, 8'h00}, rd);
        check(rd, 32'(e));
    endtask : cfgChk
    // Sync to the refresh toggle first so a refresh cannot relock between unlock and load
    task automatic movePtr(input logic [23:0] ma, input logic [7:0] p, input logic unlock);
        logic [31:0] s0, s1;
        io(OP_IO_WRITE, 24'h70, 8'h8d);
        ioRead(16'h61, s0);
        s1 = s0;
        n = 0;
        while (s1[4] === s0[4] && n < 300) begin
            ioRead(16'h61, s1);
            n++;
        end
        check(32'(n < 300), 32'h1);
        // Locked move skips the unlock read, so the load must be ignored
        if (unlock) ioRead(16'h74, s1);
        check(32'(link.ptrUnlocked), 32'(unlock));
        io(OP_MEM_WRITE, ma, p);
        repeat (3) @(posedge sys_clk);
        #1 check(32'(link.ptrUnlocked), 32'h0);
    endtask : movePtr
    // Counts select cycles; 140 covers the longest command width
    task automatic pulse(input logic [15:0] a);
        na = 0;
        nb = 0;
        io(OP_IO_READ, 24'(a), 8'h00);
        repeat (140) begin
            @(posedge sys_clk);
            #1 na += int'(portASelect);
            nb += int'(portBSelect);
        end
    endtask : pulse
    task automatic nmiChk(input logic e);
        repeat (3) @(posedge sys_clk);
        #1 check(32'(nmiReq), 32'(e));
    endtask : nmiChk
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    initial begin
        #400000;
        errorCnt++;
        results();
    end
    initial begin
        {channelCheck, parityError, watchdogEnable, watchdogTimeout, swWr, swRd} = 6'h0;
        boardSerialEn = 2'b01;
        swAddr = 8'h00;
        swWrData = 32'h0;
        ptr = PTR_RESET;
        resetn = 1'b0;
        repeat (6) @(posedge sys_clk);
        resetn <= 1'b1;
        io(OP_IO_WRITE, 24'h70, 8'h8d);
        for (int i = 0; i < 7; i++) begin
            cfgChk(8'h20 + 8'(i), 8'h00);
            cfgWr(8'h20 + 8'(i), 8'hff);
            cfgChk(8'h20 + 8'(i), i == 0 ? PS_WRITABLE_MASK : (i % 3 == 1 ? PC_WRITABLE_MASK : 8'hff));
        end
        cfgWr(8'h40, 8'h5a);
        cfgChk(8'h40, 8'h00);
        cfgWr(8'ha0, 8'h00);
        cfgChk(8'ha0, 8'h00);
        cfgChk(8'h20, PS_WRITABLE_MASK);
        $display("registers done");
        io(OP_IO_WRITE, 24'h70, 8'h00);
        ioRead(16'h74, rd);
        check(32'(link.ptrUnlocked), 32'h0);
        movePtr(24'h0ffffd, 8'h12, 1'b1);
        ptr = 8'h12;
        cfgChk(8'h20, PS_WRITABLE_MASK);
        ioRead(16'h0700, rd);
        check(rd, 32'h0);
        movePtr(24'h0ffffd, 8'h34, 1'b0);
        movePtr(24'h0ffffd, 8'h34, 1'b0);
        cfgChk(8'h20, PS_WRITABLE_MASK);
        ioRead(16'h74, rd);
        check(32'(link.ptrUnlocked), 32'h1);
        n = 0;
        while (link.ptrUnlocked === 1'b1 && n < 2100) begin
            @(posedge sys_clk);
            #1 n++;
        end
        check(32'(n < 1960), 32'h1);
        swWrite(HR_CONFIG, 32'h1);
        movePtr(24'hfffffd, 8'hff, 1'b1);
        ptr = 8'hff;
        cfgChk(8'h20, PS_WRITABLE_MASK);
        movePtr(24'hfffffd, 8'h04, 1'b1);
        ptr = 8'h04;
        cfgChk(8'h20, PS_WRITABLE_MASK);
        $display("pointer done");
        cfgWr(8'h20, 8'h83);
        nmiChk(1'b0);
        check({30'h0, serialEnable}, 32'h2);
        check({30'h0, secondSerialPrimary, timerTest}, 32'h1);
        cfgWr(8'h20, 8'h0c);
        nmiChk(1'b0);
        check({28'h0, serialEnable, secondSerialPrimary, timerTest}, 32'h6);
        $display("serial done");
        cfgWr(8'h23, 8'h03);
        cfgWr(8'h22, 8'h00);
        cfgWr(8'h26, 8'h05);
        cfgWr(8'h25, 8'h00);
        cfgWr(8'h24, 8'h00);
        for (int c = 0; c < 8; c++) begin
            cfgWr(8'h21, 8'h80 | 8'(c));
            pulse(16'h0300 + (16'h2 << c) - 16'h1);
            check(na, c == 7 ? 0 : 9);
            pulse(16'h0300 + (16'h2 << c));
            check(na, 0);
        end
        for (int w = 0; w < 8; w++) begin
            cfgWr(8'h21, 8'h80 | 8'(w << 4));
            pulse(16'h0301);
            check(na, ((w == 0 ? 70 : 140 * w) + 7) / 8);
        end
        cfgWr(8'h24, 8'h81);
        pulse(16'h0503);
        check(na, 0);
        check(nb, 9);
        cfgWr(8'h24, 8'h01);
        pulse(16'h0503);
        check(nb, 0);
        $display("ports done");
        io(OP_IO_WRITE, 24'h70, 8'h0d);
        channelCheck <= 1'b1;
        nmiChk(1'b0);
        io(OP_IO_WRITE, 24'h61, 8'h00);
        nmiChk(1'b1);
        channelCheck <= 1'b0;
        io(OP_IO_WRITE, 24'h61, 8'h0c);
        nmiChk(1'b0);
        parityError <= 1'b1;
        io(OP_IO_WRITE, 24'h61, 8'h08);
        nmiChk(1'b1);
        parityError <= 1'b0;
        io(OP_IO_WRITE, 24'h61, 8'h0c);
        nmiChk(1'b0);
        watchdogEnable <= 1'b1;
        watchdogTimeout <= 1'b1;
        @(posedge sys_clk);
        watchdogTimeout <= 1'b0;
        nmiChk(1'b1);
        watchdogEnable <= 1'b0;
        nmiChk(1'b0);
        $display("nmi done");
        results();
    end
endmodule : test_setup_space_port_decode
`default_nettype wire
